// ===== rtl/free_run_timer_capture_pair.v
// free-running 16-bit timer with two capture pairs behind AXI4-Lite
// assumes: single clock, capture pins asynchronous, software on
// the bus, service-start pulses from the transfer engine
`timescale 1ns/1ps
`include "frt_capture_defines.vh"

module free_run_timer_capture_pair (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [5:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [5:0]  s_axi_araddr,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // read-modify-write qualifier and service starts
  input  wire        rmw_read,
  input  wire        service_ovf,
  input  wire [3:0]  service_chan,
  // count-clock enable and capture pins
  input  wire        count_tick,
  input  wire [3:0]  capture_input_pins,
  // interrupt requests
  output reg         overflow_irq,
  output reg  [3:0]  capture_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [15:0] count_value_reg;
  reg  [15:0] count_value_next;
  reg  [2:0]  prescale_sel_reg;
  reg         stop_reg;
  reg         overflow_irq_enable_reg;
  reg         overflow_flag_reg;
  reg         wrap_pending_reg;
  reg  [7:0]  sel_en_reg;        // edge select bits, both pairs
  reg  [5:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         aw_full_reg;
  reg         w_full_reg;
  reg         tick_sync1_reg;
  reg         tick_sync2_reg;

  wire [3:0]  edge_flag;
  wire [15:0] capt_value [0:3];
  wire        wr_go;
  wire        rd_go;
  wire        wr_word;
  wire        wr_low;
  wire        tick;
  wire [3:0]  flag_clear;
  reg  [31:0] rd_mux;
  reg  [1:0]  rd_resp;
  reg         wr_ok;

  // ----------------------------------------------------------------
  // write channels: address and data taken in either order
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 6'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_full_reg && !s_axi_awready
          && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_full_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg && !s_axi_wready
          && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_full_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_go   = aw_full_reg && w_full_reg && !s_axi_bvalid;
  // the counter only accepts a full halfword, never split bytes
  assign wr_word = wr_go && (w_strb_reg[1:0] == 2'h3);
  assign wr_low  = wr_go && w_strb_reg[0];

  // unmapped or a byte-split count write answers slverr
  always @* begin
    case (aw_addr_reg[5:2])
      4'h0:    wr_ok = (w_strb_reg[1:0] == 2'h3);
      4'h1, 4'h2, 4'h3, 4'h8: wr_ok = 1'b1;
      4'h4, 4'h5, 4'h6, 4'h7: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // count-clock enable arrives from a prescaler outside this clock
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_sync1_reg <= 1'b0;
      tick_sync2_reg <= 1'b0;
    end else begin
      tick_sync1_reg <= count_tick;
      tick_sync2_reg <= tick_sync1_reg;
    end
  end

  assign tick = tick_sync2_reg;

  // ----------------------------------------------------------------
  // counter next value; immediate clears beat the wrap clear
  // ----------------------------------------------------------------
  always @* begin
    count_value_next = count_value_reg;
    if (wr_low && aw_addr_reg[5:2] == 4'h1
        && w_data_reg[`TC_CLEAR_BIT]) begin
      count_value_next = `COUNT_RESET;
    end else if (wr_word && aw_addr_reg[5:2] == 4'h0 && stop_reg) begin
      // zero write lands as a clear, any other value as a load
      count_value_next = w_data_reg[15:0];
    end else if (wrap_pending_reg && tick) begin
      count_value_next = `COUNT_RESET;
    end else if (!stop_reg && tick) begin
      count_value_next = count_value_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // counter, timer control and overflow flag
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_value_reg         <= `COUNT_RESET;
      prescale_sel_reg        <= 3'h0;
      stop_reg                <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
      overflow_flag_reg       <= 1'b0;
      wrap_pending_reg        <= 1'b0;
    end else begin
      count_value_reg <= count_value_next;
      if (wrap_pending_reg && tick) begin
        wrap_pending_reg <= 1'b0;
      end
      if (wr_low && aw_addr_reg[5:2] == 4'h1) begin
        prescale_sel_reg <=
          w_data_reg[`TC_PRESCALE_MSB:`TC_PRESCALE_LSB];
        stop_reg                <= w_data_reg[`TC_STOP_BIT];
        overflow_irq_enable_reg <= w_data_reg[`TC_OVF_IRQ_EN_BIT];
        if (w_data_reg[`TC_CLEAR_BIT]) begin
          wrap_pending_reg <= 1'b0;
        end
      end
      // the flag rises as the counter leaves all ones; set wins
      if (!stop_reg && tick && !wrap_pending_reg
          && count_value_reg == `COUNT_MAX
          && count_value_next == `COUNT_MAX + 16'h0001) begin
        overflow_flag_reg <= 1'b1;
      end else if ((wr_low && aw_addr_reg[5:2] == 4'h1
                    && !w_data_reg[`TC_OVF_FLAG_BIT]) || service_ovf) begin
        overflow_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // capture control pairs: a is channels 0,1, b is channels 2,3
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sel_en_reg <= 8'h00;
    end else begin
      if (wr_low && aw_addr_reg[5:2] == 4'h2) begin
        sel_en_reg[3:0] <= w_data_reg[3:0];
      end
      if (wr_low && aw_addr_reg[5:2] == 4'h3) begin
        sel_en_reg[7:4] <= w_data_reg[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // four channels, two per pair; irq enables held in bits 4,5
  // ----------------------------------------------------------------
  reg [1:0] ien_a_reg;
  reg [1:0] ien_b_reg;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ien_a_reg <= 2'h0;
      ien_b_reg <= 2'h0;
    end else begin
      if (wr_low && aw_addr_reg[5:2] == 4'h2) begin
        ien_a_reg <= w_data_reg[`CP_IRQ_EN1_BIT:`CP_IRQ_EN0_BIT];
      end
      if (wr_low && aw_addr_reg[5:2] == 4'h3) begin
        ien_b_reg <= w_data_reg[`CP_IRQ_EN1_BIT:`CP_IRQ_EN0_BIT];
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : chan
      // write of 0 to the flag bit clears, 1 leaves it alone
      assign flag_clear[ch] = service_chan[ch] ||
        (wr_low && aw_addr_reg[5:2] == ((ch < 2) ? 4'h2 : 4'h3)
         && !w_data_reg[`CP_FLAG0_BIT + (ch % 2)]);
      capture_channel u_chan (
        .clk_sys           (clk_sys),
        .rstn              (rstn),
        .pin               (capture_input_pins[ch]),
        .count             (count_value_reg),
        .edge_sel          (sel_en_reg[2*ch+1:2*ch]),
        .flag_clear        (flag_clear[ch]),
        .flag_reg          (edge_flag[ch]),
        .capture_value_reg (capt_value[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt requests straight from flops
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      overflow_irq <= 1'b0;
      capture_irq  <= 4'h0;
    end else begin
      overflow_irq <= overflow_flag_reg & overflow_irq_enable_reg;
      capture_irq  <= edge_flag & {ien_b_reg, ien_a_reg};
    end
  end

  // ----------------------------------------------------------------
  // read mux; rmw reads see flags as 1 so write-back keeps them
  // ----------------------------------------------------------------
  always @* begin
    rd_mux  = 32'h00000000;
    rd_resp = `AXI_OKAY;
    case (s_axi_araddr[5:2])
      4'h0: rd_mux[15:0] = count_value_reg;
      4'h1: rd_mux[7:0] = {overflow_flag_reg | rmw_read,
                           overflow_irq_enable_reg, stop_reg,
                           2'b00, prescale_sel_reg};
      4'h2: rd_mux[7:0] = {edge_flag[1:0] | {2{rmw_read}},
                           ien_a_reg, sel_en_reg[3:0]};
      4'h3: rd_mux[7:0] = {edge_flag[3:2] | {2{rmw_read}},
                           ien_b_reg, sel_en_reg[7:4]};
      4'h4: rd_mux[15:0] = capt_value[0];
      4'h5: rd_mux[15:0] = capt_value[1];
      4'h6: rd_mux[15:0] = capt_value[2];
      4'h7: rd_mux[15:0] = capt_value[3];
      4'h8: rd_mux = 32'h00000000;
      default: rd_resp = `AXI_SLVERR;
    endcase
  end

  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  // ----------------------------------------------------------------
  // read channels: one outstanding read, answer raised with address ready
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== shared/frt_capture_defines.vh
// offsets, field positions, edge codes and reset values of the
// free-running timer with two capture pairs
// assumes: included by bare name from the design files
`ifndef FRT_CAPTURE_DEFINES_VH
`define FRT_CAPTURE_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OFS_COUNT_VALUE    5'h00
`define OFS_TIMER_CTRL     5'h04
`define OFS_PAIR_A_CTRL    5'h08
`define OFS_PAIR_B_CTRL    5'h0C
`define OFS_CAPT_VALUE0    5'h10
`define OFS_CAPT_VALUE1    5'h14
`define OFS_CAPT_VALUE2    5'h18
`define OFS_CAPT_VALUE3    5'h1C
`define OFS_SERVICE_ACK    5'h20

// ----------------------------------------------------------------
// timer control fields
// ----------------------------------------------------------------
`define TC_PRESCALE_LSB    0
`define TC_PRESCALE_MSB    2
`define TC_CLEAR_BIT       3
`define TC_STOP_BIT        5
`define TC_OVF_IRQ_EN_BIT  6
`define TC_OVF_FLAG_BIT    7

// ----------------------------------------------------------------
// capture pair control fields
// ----------------------------------------------------------------
`define CP_SEL0_LSB        0
`define CP_SEL1_LSB        2
`define CP_IRQ_EN0_BIT     4
`define CP_IRQ_EN1_BIT     5
`define CP_FLAG0_BIT       6
`define CP_FLAG1_BIT       7

// ----------------------------------------------------------------
// edge select codes
// ----------------------------------------------------------------
`define EDGE_OFF           2'h0
`define EDGE_RISE          2'h1
`define EDGE_FALL          2'h2
`define EDGE_BOTH          2'h3

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define COUNT_RESET        16'h0000
`define COUNT_MAX          16'hFFFF
`define CTRL_RESET         8'h00
`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2

`endif

// ===== rtl/capture_channel.v
// one capture channel: pin synchroniser, edge select, sticky flag
// and captured counter value
// assumes: pin is asynchronous; count is on clk_sys
`timescale 1ns/1ps
`include "frt_capture_defines.vh"

module capture_channel (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // pin and counter
  input  wire        pin,
  input  wire [15:0] count,
  // control
  input  wire [1:0]  edge_sel,
  input  wire        flag_clear,
  // results
  output reg         flag_reg,
  output reg  [15:0] capture_value_reg
);

  reg  sync1_reg;
  reg  sync2_reg;
  reg  prev_reg;
  wire rise;
  wire fall;
  reg  hit;

  // ----------------------------------------------------------------
  // synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // edge qualification; code zero keeps the channel idle
  always @* begin
    case (edge_sel)
      `EDGE_RISE: hit = rise;
      `EDGE_FALL: hit = fall;
      `EDGE_BOTH: hit = rise | fall;
      default:    hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // sticky flag and capture; a new edge wins over a clear
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag_reg          <= 1'b0;
      capture_value_reg <= `COUNT_RESET;
    end else begin
      if (hit) begin
        flag_reg          <= 1'b1;
        capture_value_reg <= count;
      end else if (flag_clear) begin
        flag_reg <= 1'b0;
      end
    end
  end

endmodule

// ===== dv/capture_pin_source.sv
// pin source standing in for the external signals on capture pins
// assumes: the block synchronises the pins, so no setup is kept
`timescale 1ns/1ps

module capture_pin_source (
  // clock
  input  wire        clk_sys,
  // pins toward the block
  output logic [3:0] capture_input_pins
);
  // pins idle low until a scenario moves one
  initial capture_input_pins = 4'h0;

  // move one pin just after an edge, like a real source off-clock
  // static on purpose: the index of a non-blocking target stays legal
  task set_pin(input int k, input logic v);
    @(posedge clk_sys);
    capture_input_pins[k] <= v;
  endtask
endmodule

// ===== dv/frt_capture_props.sv
// checker for the timer block: bus handshakes, error answers and
// read-modify-write flag reads
// assumes: bound to the top module, one clock, rstn async low
`timescale 1ns/1ps

module frt_capture_props (
  // clock and reset
  input wire        clk_sys,
  input wire        rstn,
  // write side
  input wire        s_axi_awready,
  input wire [5:0]  s_axi_awaddr,
  input wire        s_axi_wready,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  // read side
  input wire        s_axi_arready,
  input wire [5:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        rmw_read
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // handshake steps
  // ------------------------------------------------------------
  sequence wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence

  sequence rd_taken(a);
    s_axi_arready && s_axi_rvalid && s_axi_araddr == a;
  endsequence

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
  b_follows_a: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  r_answer_a: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read data not with address ready");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  unmapped_err_a: assert property (s_axi_arready &&
    s_axi_araddr > 6'h23 |-> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  word_load_a: assert property (
    wr_taken ##0 (s_axi_awaddr == 6'h00 && s_axi_wstrb[1:0] != 2'h3)
    |=> s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("partial count write not refused");
  clear_zero_a: assert property (
    rd_taken(6'h04) |-> !s_axi_rdata[3])
    else $error("clear bit read back as one");
  rmw_pair_a: assert property (
    (rd_taken(6'h08) or rd_taken(6'h0C)) ##0 rmw_read
    |-> s_axi_rdata[7:6] == 2'h3)
    else $error("pair flags not one on modify read");
  rmw_ovf_a: assert property (
    rd_taken(6'h04) ##0 rmw_read |-> s_axi_rdata[7])
    else $error("overflow flag not one on modify read");
endmodule

bind free_run_timer_capture_pair frt_capture_props props_u (
  .clk_sys, .rstn, .s_axi_awready, .s_axi_awaddr, .s_axi_wready,
  .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .rmw_read);

// ===== dv/free_run_timer_capture_pair_bench.sv
// bench for the timer block: register tasks on the bus, counter,
// overflow and capture scenarios
// assumes: checker bound in its own file, pin source alongside
`timescale 1ns/1ps

module free_run_timer_capture_pair_bench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk_sys, rstn, rmw_read, service_ovf, count_tick;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd, prev;
  logic [3:0]  s_axi_wstrb, service_chan;
  logic [1:0]  rsp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, overflow_irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  capture_input_pins, capture_irq;
  int          fail_count = 0, samples_checked = 0, cycles = 0;

  free_run_timer_capture_pair dut_u (
    .clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .rmw_read, .service_ovf,
    .service_chan, .count_tick, .capture_input_pins, .overflow_irq,
    .capture_irq);

  capture_pin_source src_u (.clk_sys, .capture_input_pins);

  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // cut a hang short; the scenarios need about twelve hundred and fifty cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // both channels offered together, each dropped when taken
  task automatic wr(input [5:0] a, input [31:0] d, input [3:0] s);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    while (!(aw_d && w_d)) begin
      @(posedge clk_sys);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_d = 1'b1;
      end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    // ready only once the answer stands, so its hold gets exercised
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // read, optionally flagged as part of a read-modify-write
  task automatic rdr(input [5:0] a, input logic m);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    rmw_read <= m;
    do @(posedge clk_sys); while (!s_axi_arready);
    // address taken; read ready follows late so the data must hold
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    rmw_read <= 1'b0;
  endtask

  task automatic rchk(input [5:0] a, input [31:0] e);
    rdr(a, 1'b0);
    check(rd, e);
  endtask

  // load near the top, run and wait for the wrap
  task automatic ovf_run();
    wr(6'h04, 32'h20, 4'h1);
    wr(6'h00, 32'hFFF0, 4'h3);
    wr(6'h04, 32'h40, 4'h1);
    for (int i = 0; i < 40 && overflow_irq !== 1'b1; i++)
      @(posedge clk_sys);
    check(32'(overflow_irq), 32'h1);
    rchk(6'h04, 32'hC0);
    rdr(6'h00, 1'b0);
    check(32'(rd < 32'h40), 32'h1);
  endtask

  // one channel in one edge mode: rise, fall, then clear the flag
  task automatic cap_case(input int k, input int m);
    logic [5:0] a;
    int j;
    logic ie, f_r, f_b;
    j = k % 2;
    a = (k < 2) ? 6'h08 : 6'h0C;
    ie = (m != 2);
    f_r = (m == 1 || m == 3);
    f_b = (m != 0);
    wr(a, (m << (2*j)) | (ie << (4+j)) | ((m == 0) << (6+j)),
       4'h1);
    // flag plus interrupt settle within six edges of a pin change
    src_u.set_pin(k, 1'b1);
    repeat (6) @(posedge clk_sys);
    rdr(a, 1'b0);
    check(32'(rd[6+j]), 32'(f_r));
    check(32'(capture_irq[k]), 32'(f_r & ie));
    src_u.set_pin(k, 1'b0);
    repeat (6) @(posedge clk_sys);
    rdr(a, 1'b0);
    check(32'(rd[6+j]), 32'(f_b));
    check(32'(capture_irq[k]), 32'(f_b & ie));
    rchk(6'(6'h10 + 4*k), (m == 0) ? 32'h0 : 32'h0100);
    rdr(a, 1'b1);
    check(32'(rd[7:6]), 32'h3);
    // write the modify read back: flags written as 1 keep their state
    wr(a, rd, 4'h1);
    rdr(a, 1'b0);
    check(32'(rd[6+j]), 32'(f_b));
    if (m == 3) begin
      @(posedge clk_sys);
      service_chan <= 4'(1 << k);
      @(posedge clk_sys);
      service_chan <= 4'h0;
    end else
      wr(a, 32'h0, 4'h1);
    rdr(a, 1'b0);
    check(32'(rd[6+j]), 32'h0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rstn, rmw_read, service_ovf, count_tick} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, service_chan} = 20'h0;
    s_axi_wdata = 32'h0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rchk(6'h00, 32'h0);
    rchk(6'h08, 32'h0);
    rchk(6'h0C, 32'h0);
    rchk(6'h20, 32'h0);
    rdr(6'h24, 1'b0);
    check(32'(rsp), 32'h2);
    wr(6'h28, 32'h0, 4'hF);
    check(32'(rsp), 32'h2);
    // stopped counter: load, hold, refuse a byte write, zero write
    wr(6'h04, 32'h20, 4'h1);
    wr(6'h00, 32'h1234, 4'h3);
    count_tick <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rchk(6'h00, 32'h1234);
    wr(6'h00, 32'h5678, 4'h1);
    check(32'(rsp), 32'h2);
    rchk(6'h00, 32'h1234);
    wr(6'h00, 32'h0, 4'h3);
    rchk(6'h00, 32'h0);
    // running counter, wrap, flag clear by write and by service
    wr(6'h00, 32'h8000, 4'h3);
    wr(6'h04, 32'h0, 4'h1);
    rdr(6'h00, 1'b0);
    prev = rd;
    rdr(6'h00, 1'b0);
    check(32'(rd > prev), 32'h1);
    ovf_run();
    wr(6'h04, 32'h40, 4'h1);
    rchk(6'h04, 32'h40);
    check(32'(overflow_irq), 32'h0);
    rdr(6'h04, 1'b1);
    check(32'(rd[7]), 32'h1);
    ovf_run();
    @(posedge clk_sys);
    service_ovf <= 1'b1;
    @(posedge clk_sys);
    service_ovf <= 1'b0;
    rchk(6'h04, 32'h40);
    repeat (200) @(posedge clk_sys);
    wr(6'h04, 32'h48, 4'h1);
    rdr(6'h00, 1'b0);
    check(32'(rd < 32'h10), 32'h1);
    // captures against a stopped counter, every channel and mode
    wr(6'h04, 32'h20, 4'h1);
    wr(6'h00, 32'h0100, 4'h3);
    for (int k = 0; k < 4; k++)
      for (int m = 0; m < 4; m++)
        cap_case(k, m);
    print_verdict();
  end
endmodule
